// file: core/chandler_pkg.sv
// constants for the transmit cell handler register bank
// assumes a 32-bit word-aligned bus; index times four is the byte address
package chandler_pkg;

  // register indices (byte address = index * 4)
  localparam logic [4:0] IDX_ROF_MID      = 5'h00;
  localparam logic [4:0] IDX_ROF_TOP      = 5'h01;
  localparam logic [4:0] IDX_CNT_EN       = 5'h02;
  localparam logic [4:0] IDX_RESET        = 5'h04;
  localparam logic [4:0] IDX_CMD          = 5'h05;
  localparam logic [4:0] IDX_STAT_ONE     = 5'h06;
  localparam logic [4:0] IDX_STAT_TWO     = 5'h07;
  localparam logic [4:0] IDX_MAIN_PEND    = 5'h08;
  localparam logic [4:0] IDX_MAIN_MASK    = 5'h09;
  localparam logic [4:0] IDX_CNTR_PEND    = 5'h0a;
  localparam logic [4:0] IDX_CNTR_MASK    = 5'h0b;
  localparam logic [4:0] IDX_MODE         = 5'h0c;
  localparam logic [4:0] IDX_CORRUPT_THR  = 5'h0d;
  localparam logic [4:0] IDX_QUEUE_CLR    = 5'h10;
  localparam logic [4:0] IDX_QUEUE        = 5'h11;
  localparam logic [4:0] IDX_IDLE_CLR     = 5'h12;
  localparam logic [4:0] IDX_IDLE         = 5'h13;
  localparam logic [4:0] IDX_CORRUPT_CLR  = 5'h14;
  localparam logic [4:0] IDX_CORRUPT      = 5'h15;
  localparam logic [4:0] IDX_UNMAPPED     = 5'h1f;

  // bit positions
  localparam int EN_QUEUE        = 0;
  localparam int EN_IDLE         = 1;
  localparam int EN_CORRUPT      = 2;
  localparam int IRQ_QUEUE_OVF   = 0;
  localparam int IRQ_IDLE_OVF    = 1;
  localparam int IRQ_CORRUPT_OVF = 2;
  localparam int IRQ_CORRUPT_THR = 3;
  localparam int MAIN_FATAL      = 0;
  localparam int MAIN_CNTR       = 1;
  localparam int MODE_LATCH_RDCLR = 1;
  localparam int MODE_IRQ_RDCLR   = 7;
  localparam int RST_CHIPLET     = 0;
  localparam int RST_HALT        = 1;

  // reset values
  localparam logic [1:0] RESET_HALT_DEFAULT = 2'h1;
  localparam logic [7:0] MODE_DEFAULT       = 8'h82;
  localparam logic [7:0] CNT_EN_DEFAULT     = 8'h00;
  localparam logic [7:0] THR_DEFAULT        = 8'hff;
  localparam logic [7:0] MASK_DEFAULT       = 8'h00;

  typedef enum logic [0:0] {
    PH_ADDR = 1'b0,
    PH_READ = 1'b1
  } bus_phase_t;

endpackage

// file: core/chiplet_handler_regs_tx_cells.sv
// register bank of the transmit cell handler: counters, latches, irq
// assumes AHB-Lite single-word accesses and synchronous event inputs
// Function
// R1: counter advances only while its enable bit set
// R2: overflow and threshold request bits per counter; code has a threshold request for the corrupt count only
// R3: one shared latch holds upper counter bytes
// R4: read at n or n-1 gives low byte
// R5: read n keeps count; n-1 clears it
// R6: read captures upper bytes before any clear
// R7: counters read-only; writes do nothing
// R8: 16-bit top at mid; 24-bit top/mid split
// R9: host reads low byte, then mid, then top
// R10: reset bit 0 set after reset; chiplet disabled
// R11: reset bit 1 halts chiplet state machines
// R12: command write pulses one cycle; reads zero
// R13: event latch bits set and stay set
// R14: clear by write-one or by any read
// R15: main bit 0 fatal; others point onward
// R16: all masks zero after reset
// R17: pending and mask both one raise irq
// R18: mode bit 1 latches, bit 7 irqs clearing
// R19: count queue cells and idle cells, 24-bit
// R20: 8-bit corrupt count, overflow and threshold requests
// R21: reset line forces reset/halt register default
// R22: masked-in pending drives irq; counter pointer
// R23: overflow wraps to zero and sets request
`timescale 1ns/1ps
module chiplet_handler_regs_tx_cells
  import chandler_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        queueCellRead,
  input  wire logic        idleCellSent,
  input  wire logic        corruptCellRead,
  input  wire logic        fatalEvent,
  input  wire logic [7:0]  statOneEvent,
  input  wire logic [7:0]  statTwoEvent,
  input  wire logic        tx_chiplet_reset_line,
  output logic             chipletReset,
  output logic             chipletHalt,
  output logic      [7:0]  cmdPulse,
  output logic             tx_handler_irq_line
);

  typedef struct packed {
    bus_phase_t  phase;
    logic        wrPend;
    logic [4:0]  idx;
    logic        readyOut;
    logic        resp;
    logic [31:0] rdata;
    logic [23:0] queueCnt;
    logic [23:0] idleCnt;
    logic [7:0]  corruptCnt;
    logic [7:0]  corruptThr;
    logic [7:0]  cntEn;
    logic [7:0]  mode;
    logic [7:0]  statOne;
    logic [7:0]  statTwo;
    logic [7:0]  mainPend;
    logic [7:0]  mainMask;
    logic [7:0]  cntrPend;
    logic [7:0]  cntrMask;
    logic [7:0]  cmd;
    logic [7:0]  counter_mid_byte_latch;
    logic [7:0]  rofTop;
    logic [1:0]  rstHalt;
    logic        irq;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic       take;
  logic       rdNow;
  logic       wrNow;
  logic [7:0] wByte;
  logic [7:0] rdByte;
  logic       latchRdClr;
  logic       irqRdClr;
  logic       qInc;
  logic       iInc;
  logic       cInc;
  logic       qClr;
  logic       iClr;
  logic       cClr;
  logic [24:0] qSum;
  logic [24:0] iSum;
  logic [8:0]  cSum;
  logic [7:0]  cBase;

  assign hrdata              = st_reg.rdata;
  assign hreadyout           = st_reg.readyOut;
  assign hresp               = st_reg.resp;
  assign chipletReset        = st_reg.rstHalt[RST_CHIPLET]; // R10
  assign chipletHalt         = st_reg.rstHalt[RST_HALT]; // R11
  assign cmdPulse            = st_reg.cmd;
  assign tx_handler_irq_line = st_reg.irq;

  // read data mux
  always_comb begin
    case (st_reg.idx)
      IDX_ROF_MID:     rdByte = st_reg.counter_mid_byte_latch;
      IDX_ROF_TOP:     rdByte = st_reg.rofTop;
      IDX_CNT_EN:      rdByte = st_reg.cntEn;
      IDX_RESET:       rdByte = {6'h00, st_reg.rstHalt};
      IDX_STAT_ONE:    rdByte = st_reg.statOne;
      IDX_STAT_TWO:    rdByte = st_reg.statTwo;
      IDX_MAIN_PEND:   rdByte = st_reg.mainPend;
      IDX_MAIN_MASK:   rdByte = st_reg.mainMask;
      IDX_CNTR_PEND:   rdByte = st_reg.cntrPend;
      IDX_CNTR_MASK:   rdByte = st_reg.cntrMask;
      IDX_MODE:        rdByte = st_reg.mode;
      IDX_CORRUPT_THR: rdByte = st_reg.corruptThr;
      IDX_QUEUE,
      IDX_QUEUE_CLR:   rdByte = st_reg.queueCnt[7:0]; // R4
      IDX_IDLE,
      IDX_IDLE_CLR:    rdByte = st_reg.idleCnt[7:0]; // R4
      IDX_CORRUPT,
      IDX_CORRUPT_CLR: rdByte = st_reg.corruptCnt; // R4
      default:         rdByte = 8'h00; // R12
    endcase
  end

  always_comb begin
    st_next    = st_reg;
    take       = hsel && htrans[1] && hready;
    rdNow      = (st_reg.phase == PH_READ);
    wrNow      = st_reg.wrPend;
    wByte      = hwdata[7:0];
    latchRdClr = st_reg.mode[MODE_LATCH_RDCLR]; // R18
    irqRdClr   = st_reg.mode[MODE_IRQ_RDCLR]; // R18

    // bus phases: reads take one wait state so hrdata comes from a flop
    st_next.phase    = PH_ADDR;
    st_next.wrPend   = 1'b0;
    st_next.readyOut = 1'b1;
    st_next.resp     = 1'b0;
    st_next.cmd      = 8'h00; // R12
    if (take) begin
      st_next.idx = (haddr[31:7] == 25'h0) ? haddr[6:2] : IDX_UNMAPPED;
      if (hwrite) begin
        st_next.wrPend = 1'b1;
      end else begin
        st_next.phase    = PH_READ;
        st_next.readyOut = 1'b0;
      end
    end
    if (rdNow) begin
      st_next.rdata = {24'h000000, rdByte};
    end

    // counters
    qInc = queueCellRead && st_reg.cntEn[EN_QUEUE]; // R1
    iInc = idleCellSent && st_reg.cntEn[EN_IDLE]; // R1
    cInc = corruptCellRead && st_reg.cntEn[EN_CORRUPT]; // R1
    qClr = rdNow && (st_reg.idx == IDX_QUEUE_CLR); // R5
    iClr = rdNow && (st_reg.idx == IDX_IDLE_CLR); // R5
    cClr = rdNow && (st_reg.idx == IDX_CORRUPT_CLR); // R5

    // upper bytes latched from the old count, ahead of any clear
    if (rdNow && (st_reg.idx == IDX_QUEUE || st_reg.idx == IDX_QUEUE_CLR)) begin
      st_next.counter_mid_byte_latch = st_reg.queueCnt[15:8]; // R3 R6 R8
      st_next.rofTop = st_reg.queueCnt[23:16]; // R8
    end
    if (rdNow && (st_reg.idx == IDX_IDLE || st_reg.idx == IDX_IDLE_CLR)) begin
      st_next.counter_mid_byte_latch = st_reg.idleCnt[15:8]; // R3 R6 R8
      st_next.rofTop = st_reg.idleCnt[23:16]; // R8
    end

    qSum  = {1'b0, (qClr ? 24'h000000 : st_reg.queueCnt)} + 25'h0000001;
    iSum  = {1'b0, (iClr ? 24'h000000 : st_reg.idleCnt)} + 25'h0000001;
    cBase = cClr ? 8'h00 : st_reg.corruptCnt;
    cSum  = {1'b0, cBase} + 9'h001;
    if (qClr) st_next.queueCnt = 24'h000000;
    if (iClr) st_next.idleCnt = 24'h000000;
    if (cClr) st_next.corruptCnt = 8'h00;

    // interrupt request clearing, then new requests win
    if (rdNow && irqRdClr && st_reg.idx == IDX_CNTR_PEND) begin
      st_next.cntrPend = 8'h00; // R14 R17
    end
    if (wrNow && !irqRdClr && st_reg.idx == IDX_CNTR_PEND) begin
      st_next.cntrPend = st_reg.cntrPend & ~wByte; // R14 R17
    end
    if (qInc) begin
      st_next.queueCnt = qSum[23:0]; // R19 R23
      if (qSum[24]) st_next.cntrPend[IRQ_QUEUE_OVF] = 1'b1; // R2 R19
    end
    if (iInc) begin
      st_next.idleCnt = iSum[23:0]; // R19 R23
      if (iSum[24]) st_next.cntrPend[IRQ_IDLE_OVF] = 1'b1; // R2 R19
    end
    if (cInc) begin
      st_next.corruptCnt = cSum[7:0]; // R20 R23
      if (cSum[8]) st_next.cntrPend[IRQ_CORRUPT_OVF] = 1'b1; // R2 R20
      if (cSum[8] == 1'b0 && cSum[7:0] > st_reg.corruptThr && cBase <= st_reg.corruptThr) begin
        st_next.cntrPend[IRQ_CORRUPT_THR] = 1'b1; // R2 R20
      end
    end

    // event latches
    if (rdNow && latchRdClr && st_reg.idx == IDX_STAT_ONE) st_next.statOne = 8'h00; // R14
    if (rdNow && latchRdClr && st_reg.idx == IDX_STAT_TWO) st_next.statTwo = 8'h00; // R14
    if (wrNow && !latchRdClr && st_reg.idx == IDX_STAT_ONE) begin
      st_next.statOne = st_reg.statOne & ~wByte; // R14
    end
    if (wrNow && !latchRdClr && st_reg.idx == IDX_STAT_TWO) begin
      st_next.statTwo = st_reg.statTwo & ~wByte; // R14
    end
    st_next.statOne = st_next.statOne | statOneEvent; // R13
    st_next.statTwo = st_next.statTwo | statTwoEvent; // R13

    // main interrupt: sticky fatal bit and counter pointer
    if (rdNow && irqRdClr && st_reg.idx == IDX_MAIN_PEND) begin
      st_next.mainPend[MAIN_FATAL] = 1'b0; // R17
    end
    if (wrNow && !irqRdClr && st_reg.idx == IDX_MAIN_PEND && wByte[MAIN_FATAL]) begin
      st_next.mainPend[MAIN_FATAL] = 1'b0; // R17
    end
    if (fatalEvent) st_next.mainPend[MAIN_FATAL] = 1'b1; // R15

    // plain writes; counters and commands readback stay untouched
    if (wrNow) begin
      case (st_reg.idx)
        IDX_CNT_EN:      st_next.cntEn = wByte;
        IDX_RESET:       st_next.rstHalt = wByte[1:0]; // R10 R11
        IDX_CMD:         st_next.cmd = wByte; // R12
        IDX_MAIN_MASK:   st_next.mainMask = wByte;
        IDX_CNTR_MASK:   st_next.cntrMask = wByte;
        IDX_MODE:        st_next.mode = wByte;
        IDX_CORRUPT_THR: st_next.corruptThr = wByte;
        default:         st_next.cntEn = st_next.cntEn; // R7
      endcase
    end
    if (tx_chiplet_reset_line) st_next.rstHalt = RESET_HALT_DEFAULT; // R21

    st_next.mainPend[MAIN_CNTR] = |(st_next.cntrPend & st_next.cntrMask); // R15 R22
    st_next.mainPend[7:2]       = 6'h00;
    st_next.irq = |(st_next.mainPend & st_next.mainMask); // R17 R22
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg            <= '0;
      st_reg.phase      <= PH_ADDR;
      st_reg.readyOut   <= 1'b1;
      st_reg.corruptThr <= THR_DEFAULT;
      st_reg.cntEn      <= CNT_EN_DEFAULT;
      st_reg.mode       <= MODE_DEFAULT;
      st_reg.mainMask   <= MASK_DEFAULT; // R16
      st_reg.cntrMask   <= MASK_DEFAULT; // R16
      st_reg.rstHalt    <= RESET_HALT_DEFAULT; // R10
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_count_hold: assert property ( // R1
    !st_reg.cntEn[EN_QUEUE] && !(rdNow && st_reg.idx == IDX_QUEUE_CLR)
      |=> $stable(st_reg.queueCnt))
    else $error("queue count moved while disabled");

  a_read_latch: assert property ( // R6
    rdNow && st_reg.idx == IDX_QUEUE
      |=> st_reg.counter_mid_byte_latch == $past(st_reg.queueCnt[15:8])
          && st_reg.rofTop == $past(st_reg.queueCnt[23:16])
          && (st_reg.queueCnt - $past(st_reg.queueCnt)) <= 24'h000001)
    else $error("readback latch or count wrong after read");

  a_clear_read: assert property ( // R5
    rdNow && st_reg.idx == IDX_IDLE_CLR |=> st_reg.idleCnt <= 24'h000001)
    else $error("idle count not cleared by clearing read");

  a_cmd_pulse: assert property ( // R12
    wrNow && st_reg.idx == IDX_CMD && !take
      |=> cmdPulse == $past(wByte) ##1 cmdPulse == 8'h00)
    else $error("command pulse not exactly one cycle");

  a_reset_force: assert property ( // R21
    tx_chiplet_reset_line |=> chipletReset && !chipletHalt)
    else $error("reset line did not force default");

  a_irq_line: assert property ( // R17
    tx_handler_irq_line == |(st_reg.mainPend & st_reg.mainMask))
    else $error("irq line disagrees with pending and mask");

  a_latch_sticky: assert property ( // R13
    st_reg.statOne[0] && !(rdNow || wrNow) |=> st_reg.statOne[0])
    else $error("event latch bit lost without clear");

  a_overflow_wrap: assert property ( // R23
    cInc && !cClr && st_reg.corruptCnt == 8'hff
      |=> st_reg.corruptCnt == 8'h00 && st_reg.cntrPend[IRQ_CORRUPT_OVF])
    else $error("corrupt counter did not wrap with request");

  a_read_wait: assert property ( // R4
    take && !hwrite |=> !hreadyout ##1 (hreadyout && hrdata[31:8] == 24'h000000))
    else $error("read data phase timing wrong");

  a_fatal_set: assert property ( // R15
    fatalEvent |=> st_reg.mainPend[MAIN_FATAL])
    else $error("fatal event did not set main bit 0");

  a_idle_hold: assert property ( // R1
    !st_reg.cntEn[EN_IDLE] && !(rdNow && st_reg.idx == IDX_IDLE_CLR)
      |=> $stable(st_reg.idleCnt))
    else $error("idle count moved while disabled");

  a_corrupt_hold: assert property ( // R1
    !st_reg.cntEn[EN_CORRUPT] && !(rdNow && st_reg.idx == IDX_CORRUPT_CLR)
      |=> $stable(st_reg.corruptCnt))
    else $error("corrupt count moved while disabled");

  a_queue_clear: assert property ( // R5
    rdNow && st_reg.idx == IDX_QUEUE_CLR |=> st_reg.queueCnt <= 24'h000001)
    else $error("queue count not cleared by clearing read");

  a_corrupt_clear: assert property ( // R5
    rdNow && st_reg.idx == IDX_CORRUPT_CLR |=> st_reg.corruptCnt <= 8'h01)
    else $error("corrupt count not cleared by clearing read");

  a_idle_latch: assert property ( // R6
    rdNow && st_reg.idx == IDX_IDLE_CLR
      |=> st_reg.counter_mid_byte_latch == $past(st_reg.idleCnt[15:8])
          && st_reg.rofTop == $past(st_reg.idleCnt[23:16]))
    else $error("readback latch wrong after clearing read");

  a_count_ro: assert property ( // R7
    wrNow && (st_reg.idx == IDX_QUEUE || st_reg.idx == IDX_QUEUE_CLR) && !queueCellRead
      |=> $stable(st_reg.queueCnt))
    else $error("write changed the queue count");

  a_cmd_read: assert property ( // R12
    rdNow && st_reg.idx == IDX_CMD |=> hrdata == 32'h00000000)
    else $error("command register read back nonzero");

  a_reset_bit: assert property ( // R10
    $rose(nrst) |-> chipletReset && !chipletHalt)
    else $error("reset register not at default after reset");

  a_mask_reset: assert property ( // R16
    $rose(nrst) |-> st_reg.mainMask == 8'h00 && st_reg.cntrMask == 8'h00)
    else $error("interrupt masks not zero after reset");

  a_latch_rdclr: assert property ( // R14
    rdNow && latchRdClr && st_reg.idx == IDX_STAT_TWO && statTwoEvent == 8'h00
      |=> st_reg.statTwo == 8'h00)
    else $error("event latch not cleared by read");

  a_latch_w1c: assert property ( // R14
    wrNow && !latchRdClr && st_reg.idx == IDX_STAT_ONE
      |=> (st_reg.statOne & $past(wByte) & ~$past(statOneEvent)) == 8'h00)
    else $error("event latch not cleared by writing one");

  a_thr_cross: assert property ( // R20
    cInc && !cClr && st_reg.corruptCnt == st_reg.corruptThr && st_reg.corruptThr != 8'hff
      |=> st_reg.cntrPend[IRQ_CORRUPT_THR])
    else $error("threshold crossing did not raise a request");

  a_main_pointer: assert property ( // R22
    st_reg.mainPend[MAIN_CNTR] == |(st_reg.cntrPend & st_reg.cntrMask))
    else $error("main pointer bit disagrees with counter requests");

  a_queue_step: assert property ( // R19
    qInc && !qClr |=> st_reg.queueCnt == $past(st_reg.queueCnt) + 24'h000001)
    else $error("queue count did not step by one");

endmodule // chiplet_handler_regs_tx_cells

// file: tb/cell_event_model.sv
// far-side chiplet model: bursts of cell event pulses
// assumes one request at a time, taken while not busy
`timescale 1ns/1ps
module cell_event_model (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [1:0]  kind,
  input  wire logic [15:0] count,
  input  wire logic        spaced,
  output logic             queueCellRead,
  output logic             idleCellSent,
  output logic             corruptCellRead,
  output logic             busy
);
  logic [15:0] left;
  logic        rest;
  assign busy = (left != 16'h0000);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      left            <= 16'h0000;
      rest            <= 1'b0;
      queueCellRead   <= 1'b0;
      idleCellSent    <= 1'b0;
      corruptCellRead <= 1'b0;
    end else begin
      queueCellRead   <= 1'b0;
      idleCellSent    <= 1'b0;
      corruptCellRead <= 1'b0;
      rest            <= 1'b0;
      if (start && !busy) begin
        left <= count;
      end else if (busy && !rest) begin
        // one pulse per cell, optionally with a gap cycle
        queueCellRead   <= (kind == 2'h0);
        idleCellSent    <= (kind == 2'h1);
        corruptCellRead <= (kind == 2'h2);
        left            <= left - 16'h0001;
        rest            <= spaced;
      end
    end
  end
endmodule // cell_event_model

// file: tb/tb.sv
// self-checking bench for the transmit cell handler register bank
// assumes one AHB-Lite master here and the cell event model beside it
`timescale 1ns/1ps
module tb;
  import chandler_pkg::*;
  logic        ref_clk, nrst, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans, kind;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] count;
  logic        start, spaced, busy, qEv, iEv, cEv, fatalEvent, resetLine;
  logic        chipletReset, chipletHalt, irq;
  logic [7:0]  statOneEvent, statTwoEvent, cmdPulse;
  int          fails, numChecks;

  chiplet_handler_regs_tx_cells i_dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .queueCellRead(qEv), .idleCellSent(iEv), .corruptCellRead(cEv),
    .fatalEvent(fatalEvent), .statOneEvent(statOneEvent), .statTwoEvent(statTwoEvent),
    .tx_chiplet_reset_line(resetLine), .chipletReset(chipletReset),
    .chipletHalt(chipletHalt), .cmdPulse(cmdPulse), .tx_handler_irq_line(irq));

  cell_event_model i_cells (.ref_clk(ref_clk), .nrst(nrst), .start(start), .kind(kind),
    .count(count), .spaced(spaced), .queueCellRead(qEv), .idleCellSent(iEv),
    .corruptCellRead(cEv), .busy(busy));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task end_of_test();
    $display("checks %0d fails %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; waits for hready at both phases
  task bus(input logic w, input logic [4:0] idx, input logic [7:0] wd,
           output logic [31:0] rd);
    haddr  <= {25'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task wr(input logic [4:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask

  task rdchk(input logic [4:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk(d, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task cells(input logic [1:0] k, input logic [15:0] n, input logic sp);
    kind   <= k;
    count  <= n;
    spaced <= sp;
    start  <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    do @(posedge ref_clk); while (busy !== 1'b0);
  endtask

  task pin_pulse(input logic f, input logic [7:0] s1, input logic [7:0] s2);
    fatalEvent   <= f;
    statOneEvent <= s1;
    statTwoEvent <= s2;
    @(posedge ref_clk);
    fatalEvent   <= 1'b0;
    statOneEvent <= 8'h00;
    statTwoEvent <= 8'h00;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; start = 1'b0; kind = 2'h0; count = 16'h0; spaced = 1'b0;
    fatalEvent = 1'b0; statOneEvent = 8'h00; statTwoEvent = 8'h00; resetLine = 1'b0;
    fails = 0; numChecks = 0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk({31'h0, chipletReset}, 32'h1);
    rdchk(IDX_RESET, 32'h1);
    rdchk(IDX_CNT_EN, 32'h0);
    rdchk(IDX_MAIN_MASK, 32'h0);
    rdchk(IDX_CNTR_MASK, 32'h0);
    rdchk(IDX_MODE, 32'h82);
    wr(IDX_UNMAPPED, 8'h55);
    rdchk(IDX_UNMAPPED, 32'h0);
    wr(IDX_RESET, 8'h02);
    @(posedge ref_clk);
    chk({31'h0, chipletReset}, 32'h0);
    chk({31'h0, chipletHalt}, 32'h1);
    resetLine <= 1'b1;
    @(posedge ref_clk);
    resetLine <= 1'b0;
    rdchk(IDX_RESET, 32'h1);
    wr(IDX_CMD, 8'h5a);
    @(posedge ref_clk);
    chk({24'h0, cmdPulse}, 32'h5a);
    @(posedge ref_clk);
    chk({24'h0, cmdPulse}, 32'h0);
    rdchk(IDX_CMD, 32'h0);
    cells(2'h0, 16'h0003, 1'b0);
    rdchk(IDX_QUEUE, 32'h0);
    wr(IDX_CNT_EN, 8'h07);
    cells(2'h0, 16'h0123, 1'b1);
    wr(IDX_QUEUE, 8'hff);
    rdchk(IDX_QUEUE, 32'h23);
    rdchk(IDX_ROF_MID, 32'h01);
    rdchk(IDX_ROF_TOP, 32'h00);
    cells(2'h1, 16'h0205, 1'b0);
    rdchk(IDX_IDLE_CLR, 32'h05);
    rdchk(IDX_ROF_MID, 32'h02);
    rdchk(IDX_IDLE, 32'h00);
    rdchk(IDX_QUEUE_CLR, 32'h23);
    rdchk(IDX_ROF_MID, 32'h01);
    rdchk(IDX_QUEUE, 32'h00);
    wr(IDX_CORRUPT_THR, 8'h03);
    cells(2'h2, 16'h0004, 1'b0);
    rdchk(IDX_CNTR_PEND, 32'h08);
    rdchk(IDX_CNTR_PEND, 32'h00);
    wr(IDX_CNTR_MASK, 8'h04);
    cells(2'h2, 16'd252, 1'b1);
    rdchk(IDX_CORRUPT_CLR, 32'h00);
    rdchk(IDX_MAIN_PEND, 32'h02);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_MAIN_MASK, 8'h02);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    pin_pulse(1'b1, 8'h00, 8'h00);
    rdchk(IDX_MAIN_PEND, 32'h03);
    rdchk(IDX_CNTR_PEND, 32'h04);
    rdchk(IDX_MAIN_PEND, 32'h00);
    chk({31'h0, irq}, 32'h0);
    pin_pulse(1'b0, 8'h00, 8'h3c);
    rdchk(IDX_STAT_TWO, 32'h3c);
    rdchk(IDX_STAT_TWO, 32'h00);
    wr(IDX_MODE, 8'h00);
    pin_pulse(1'b0, 8'h81, 8'h00);
    rdchk(IDX_STAT_ONE, 32'h81);
    rdchk(IDX_STAT_ONE, 32'h81);
    wr(IDX_STAT_ONE, 8'h01);
    rdchk(IDX_STAT_ONE, 32'h80);
    end_of_test();
  end
endmodule // tb
